// File: common/iea_pkg.sv
// constants and types for the enable, abort and command-hold control block
// assumes one core clock; register offsets are byte addresses on the plain port
// Operation
// - hold bit set: master starts nothing
// - hold bit clear: start on first entry
// - commands queued while held wait for clear
// - abort bit starts abort, reads busy
// - abort write ignored unless already enabled
// - abort: finish transfer, stop, flush transmit
// - abort completion raises transmit abort flag
// - hardware clears abort bit when finished
// - disabled: both fifos flushed and held empty
// - interrupt status kept until controller idle
// - disabled mid transmit: finish, stop, discard
// - disabled mid receive: nack current byte
// - asynchronous clocks: two cycle enable delay
// - all control bits reset to zero
// - disable forces fifo status bits empty
// - abort clear read releases transmit flush
package iea_pkg;
  // register byte offsets
  localparam logic [7:0] IEA_OFS_ENABLE = 8'h6C;
  localparam logic [7:0] IEA_OFS_STATUS = 8'h70;
  localparam logic [7:0] IEA_OFS_ABRT_CLR = 8'h54;
  localparam logic [7:0] IEA_OFS_INTR = 8'h2C;
  // controller_enable_control fields
  localparam int IEA_EN_BIT = 0;
  localparam int IEA_ABORT_BIT = 1;
  localparam int IEA_HOLD_BIT = 2;
  localparam logic IEA_ENABLE_RST = 1'b0;
  localparam logic IEA_ABORT_RST = 1'b0;
  localparam logic IEA_HOLD_DEFAULT = 1'b0; // command_hold_default
  // transfer_status_register fields
  localparam int IEA_ST_ACT = 0;
  localparam int IEA_ST_TFNF = 1;
  localparam int IEA_ST_TFE = 2;
  localparam int IEA_ST_RFNE = 3;
  localparam int IEA_ST_RFF = 4;
  localparam int IEA_ST_MST = 5;
  localparam int IEA_ST_SLV = 6;
  // masked_interrupt_status field
  localparam int IEA_INT_TXABRT = 6;
  // clock edges per byte including acknowledge
  localparam logic [3:0] IEA_BYTE_EDGES = 4'h9;
  // clock_relation_parameter value for asynchronous clocks
  localparam int IEA_CLK_ASYNC = 1;
  // abort and shutdown sequencer
  typedef enum logic [1:0] {IEA_SQ_IDLE, IEA_SQ_WAIT, IEA_SQ_STOP, IEA_SQ_DONE} iea_seq_t;
endpackage

// File: common/iea_line_if.sv
// bus line events passed from the line monitor to the control block
// assumes both ends on the core clock
`timescale 1ns/10ps
interface iea_line_if;
  logic start_det; // start condition seen, pulse
  logic stop_det;  // stop condition seen, pulse
  logic byte_end;  // byte plus acknowledge clocked out, pulse
  logic bus_busy;  // between start and stop, level
  modport mon (output start_det, output stop_det, output byte_end, output bus_busy);
  modport ctl (input start_det, input stop_det, input byte_end, input bus_busy);
endinterface

// File: rtl/iea_line_mon.sv
// watches the serial clock and data lines and reports start, stop and byte ends
// assumes both lines are asynchronous pins, sampled by the core clock
`timescale 1ns/10ps
module iea_line_mon (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // pins
  input wire logic i_scl,
  input wire logic i_sda,
  // events
  iea_line_if.mon line
);
  import iea_pkg::*;

  logic [1:0] scl_sync, next_scl_sync; // [0] is read only by [1]
  logic [1:0] sda_sync, next_sda_sync;
  logic scl_prev, next_scl_prev;
  logic sda_prev, next_sda_prev;
  logic [3:0] edge_cnt, next_edge_cnt; // rising clock edges in this byte
  logic start_q, next_start_q;
  logic stop_q, next_stop_q;
  logic byte_q, next_byte_q;
  logic busy_q, next_busy_q;
  logic scl_rise, scl_fall, is_start, is_stop;

  // edge detection runs only on the second stage
  always_comb begin
    next_scl_sync = {scl_sync[0], i_scl};
    next_sda_sync = {sda_sync[0], i_sda};
    next_scl_prev = scl_sync[1];
    next_sda_prev = sda_sync[1];
    scl_rise = scl_sync[1] && !scl_prev;
    scl_fall = !scl_sync[1] && scl_prev;
    // data moving while clock high marks start or stop
    is_start = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
    is_stop = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];
    next_start_q = is_start;
    next_stop_q = is_stop;
    next_byte_q = 1'b0;
    next_busy_q = busy_q;
    next_edge_cnt = edge_cnt;
    if (is_start) begin
      // repeated start also restarts the byte
      next_busy_q = 1'b1;
      next_edge_cnt = 4'h0;
    end else if (is_stop) begin
      next_busy_q = 1'b0;
      next_edge_cnt = 4'h0;
    end else if (busy_q && scl_rise) begin
      next_edge_cnt = edge_cnt + 4'h1;
    end else if (busy_q && scl_fall && edge_cnt == IEA_BYTE_EDGES) begin
      // acknowledge clock done, the next bit starts a new byte
      next_byte_q = 1'b1;
      next_edge_cnt = 4'h0;
    end
  end

  // idle bus lines are high
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      edge_cnt <= 4'h0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      byte_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      scl_sync <= next_scl_sync;
      sda_sync <= next_sda_sync;
      scl_prev <= next_scl_prev;
      sda_prev <= next_sda_prev;
      edge_cnt <= next_edge_cnt;
      start_q <= next_start_q;
      stop_q <= next_stop_q;
      byte_q <= next_byte_q;
      busy_q <= next_busy_q;
    end
  end

  assign line.start_det = start_q;
  assign line.stop_det = stop_q;
  assign line.byte_end = byte_q;
  assign line.bus_busy = busy_q;
endmodule

// File: rtl/iea_ctrl.sv
// enable, abort and command-hold control with its register port
// assumes the bus engine and fifos sit on the same core clock; pins are asynchronous
`timescale 1ns/10ps
module iea_ctrl #(
  parameter int FIFO_DEPTH = 16,
  parameter int CLK_TYPE = 1,
  parameter int LVL_W = $clog2(FIFO_DEPTH + 1)
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  // engine and fifo status
  input wire logic [LVL_W-1:0] i_tx_level,
  input wire logic [LVL_W-1:0] i_rx_level,
  input wire logic i_mst_active,
  input wire logic i_slv_active,
  input wire logic i_receiving,
  // engine control
  output logic o_en_core,
  output logic o_start_en,
  output logic o_stop_req,
  output logic o_nack_req,
  output logic o_tx_flush,
  output logic o_rx_flush,
  output logic o_abort_irq
);
  import iea_pkg::*;

  // refused at elaboration: depth below 2, level width too small or unknown clock relation
  if (FIFO_DEPTH < 2 || LVL_W < $clog2(FIFO_DEPTH + 1)
      || (CLK_TYPE != 0 && CLK_TYPE != IEA_CLK_ASYNC)) begin : g_bad_param
    $error("iea_ctrl: unsupported parameters");
  end

  iea_line_if line ();

  iea_line_mon u_mon (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .line(line)
  );

  // register state
  logic enable, next_enable;   // software enable
  logic abort, next_abort;     // abort in progress
  logic hold, next_hold;       // command hold
  logic en_d1, next_en_d1;     // delay stages toward the core side
  logic en_d2, next_en_d2;
  logic en_eff;                // enable as the core sees it
  // sequencer state
  iea_seq_t seq, next_seq;
  logic by_abort, next_by_abort; // sequence started by abort, not by disable
  logic tx_hold, next_tx_hold;   // transmit flushed until abort clear read
  logic txabrt, next_txabrt;     // transmit abort status flag
  // registered outputs
  logic [31:0] next_rdata;
  logic next_start_en, next_stop_req, next_nack_req;
  logic next_tx_flush, next_rx_flush;
  logic wr_en, rd_clr, idle_all, tx_empty;

  // one decode shared by writes and reads
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // control register and enable delay
  always_comb begin
    wr_en = i_wr && hit(i_addr, IEA_OFS_ENABLE);
    next_enable = enable;
    next_hold = hold;
    next_abort = abort;
    if (wr_en) begin
      // reserved bits are dropped here
      next_enable = i_wdata[IEA_EN_BIT];
      next_hold = i_wdata[IEA_HOLD_BIT];
      if (i_wdata[IEA_ABORT_BIT] && enable) begin
        next_abort = 1'b1;
      end
    end
    // only completion clears it, a written zero does nothing
    if (seq == IEA_SQ_DONE && by_abort) begin
      next_abort = 1'b0;
    end
    next_en_d1 = enable;
    next_en_d2 = en_d1;
  end

  // asynchronous relation costs two core cycles
  assign en_eff = (CLK_TYPE == IEA_CLK_ASYNC) ? en_d2 : enable;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      enable <= IEA_ENABLE_RST;
      abort <= IEA_ABORT_RST;
      hold <= IEA_HOLD_DEFAULT;
      en_d1 <= 1'b0;
      en_d2 <= 1'b0;
    end else begin
      enable <= next_enable;
      abort <= next_abort;
      hold <= next_hold;
      en_d1 <= next_en_d1;
      en_d2 <= next_en_d2;
    end
  end

  // abort and shutdown sequencer
  always_comb begin
    next_seq = seq;
    next_by_abort = by_abort;
    unique case (seq)
      IEA_SQ_IDLE: begin
        if (abort && en_eff) begin
          next_seq = IEA_SQ_WAIT;
          next_by_abort = 1'b1;
        end else if (!en_eff && line.bus_busy && (i_mst_active || i_slv_active)) begin
          // disabled mid transfer, finish the byte first
          next_seq = IEA_SQ_WAIT;
          next_by_abort = 1'b0;
        end
      end
      IEA_SQ_WAIT: begin
        // current transfer completes before the stop
        if (line.byte_end || !line.bus_busy) begin
          next_seq = (i_mst_active || by_abort) ? IEA_SQ_STOP : IEA_SQ_DONE;
        end
      end
      IEA_SQ_STOP: begin
        if (line.stop_det || !line.bus_busy) begin
          next_seq = IEA_SQ_DONE;
        end
      end
      IEA_SQ_DONE: begin
        next_seq = IEA_SQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      seq <= IEA_SQ_IDLE;
      by_abort <= 1'b0;
    end else begin
      seq <= next_seq;
      by_abort <= next_by_abort;
    end
  end

  // status flags, set wins over clear
  always_comb begin
    rd_clr = i_rd && hit(i_addr, IEA_OFS_ABRT_CLR);
    idle_all = !i_mst_active && !i_slv_active && !line.bus_busy;
    next_tx_hold = tx_hold;
    next_txabrt = txabrt;
    // reading the clear register frees the transmit path
    if (rd_clr) begin
      next_tx_hold = 1'b0;
      next_txabrt = 1'b0;
    end
    // flag survives disable until the controller is idle
    if (!en_eff && idle_all && seq == IEA_SQ_IDLE) begin
      next_txabrt = 1'b0;
    end
    if (seq == IEA_SQ_DONE && by_abort) begin
      next_txabrt = 1'b1;
      next_tx_hold = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_hold <= 1'b0;
      txabrt <= 1'b0;
    end else begin
      tx_hold <= next_tx_hold;
      txabrt <= next_txabrt;
    end
  end

  // engine controls and read data
  always_comb begin
    tx_empty = (i_tx_level == '0);
    // queued commands wait while held
    next_start_en = en_eff && !hold && !tx_empty && !tx_hold && !abort
                    && seq == IEA_SQ_IDLE;
    next_stop_req = (seq == IEA_SQ_STOP);
    // receiving byte ends with no acknowledge
    next_nack_req = (seq == IEA_SQ_WAIT) && !by_abort && i_receiving;
    // disabled means both fifos held erased
    next_tx_flush = !en_eff || tx_hold || seq == IEA_SQ_DONE;
    next_rx_flush = !en_eff;
    next_rdata = 32'h0000_0000;
    if (i_rd) begin
      if (hit(i_addr, IEA_OFS_ENABLE)) begin
        // upper bits stay zero
        next_rdata[IEA_EN_BIT] = enable;
        next_rdata[IEA_ABORT_BIT] = abort;
        next_rdata[IEA_HOLD_BIT] = hold;
      end else if (hit(i_addr, IEA_OFS_STATUS)) begin
        // disabled fifos report empty
        next_rdata[IEA_ST_TFNF] = !enable || (i_tx_level != LVL_W'(FIFO_DEPTH));
        next_rdata[IEA_ST_TFE] = !enable || tx_empty;
        next_rdata[IEA_ST_RFNE] = enable && (i_rx_level != '0);
        next_rdata[IEA_ST_RFF] = enable && (i_rx_level == LVL_W'(FIFO_DEPTH));
        next_rdata[IEA_ST_MST] = i_mst_active;
        next_rdata[IEA_ST_SLV] = i_slv_active;
        next_rdata[IEA_ST_ACT] = i_mst_active || i_slv_active;
      end else if (hit(i_addr, IEA_OFS_INTR)) begin
        next_rdata[IEA_INT_TXABRT] = txabrt;
      end else if (hit(i_addr, IEA_OFS_ABRT_CLR)) begin
        next_rdata[0] = txabrt;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 32'h0000_0000;
      o_en_core <= 1'b0;
      o_start_en <= 1'b0;
      o_stop_req <= 1'b0;
      o_nack_req <= 1'b0;
      o_tx_flush <= 1'b1;
      o_rx_flush <= 1'b1;
      o_abort_irq <= 1'b0;
    end else begin
      o_rdata <= next_rdata;
      o_en_core <= en_eff;
      o_start_en <= next_start_en;
      o_stop_req <= next_stop_req;
      o_nack_req <= next_nack_req;
      o_tx_flush <= next_tx_flush;
      o_rx_flush <= next_rx_flush;
      o_abort_irq <= txabrt;
    end
  end

  // checks on the block's own outputs and internal state
  hold_no_start_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) hold |=> !o_start_en)
    else $error("start permitted while commands are held");

  auto_start_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    en_eff && !hold && !tx_empty && !tx_hold && !abort && seq == IEA_SQ_IDLE |=> o_start_en)
    else $error("start not permitted with data waiting");

  abort_ignored_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_en && i_wdata[IEA_ABORT_BIT] && !enable && !abort |=> !abort)
    else $error("abort accepted while disabled");

  abort_sticky_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    abort && !(seq == IEA_SQ_DONE && by_abort) |=> abort)
    else $error("abort bit dropped before completion");

  abort_stop_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    $rose(seq == IEA_SQ_STOP) |-> ##1 o_stop_req)
    else $error("stop not requested during abort");

  abort_flag_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    seq == IEA_SQ_DONE && by_abort |=> txabrt ##1 o_abort_irq)
    else $error("abort flag not raised at completion");

  flag_kept_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    txabrt && !rd_clr && !(idle_all && seq == IEA_SQ_IDLE) |=> txabrt)
    else $error("abort flag lost before controller idle");

  abort_clear_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    seq == IEA_SQ_DONE && by_abort |=> !abort && o_tx_flush)
    else $error("abort bit not cleared at completion");

  disable_flush_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) !en_eff |=> o_tx_flush && o_rx_flush)
    else $error("fifos not flushed while disabled");

  status_empty_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_rd && hit(i_addr, IEA_OFS_STATUS) && !enable
    |=> o_rdata[IEA_ST_TFE] && o_rdata[IEA_ST_TFNF] && !o_rdata[IEA_ST_RFNE])
    else $error("fifo status not empty while disabled");

  reserved_zero_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_rd && hit(i_addr, IEA_OFS_ENABLE) |=> o_rdata[31:3] == 29'h0000_0000)
    else $error("reserved enable bits not zero");

  if (CLK_TYPE == IEA_CLK_ASYNC) begin : g_async_chk
    enable_delay_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      $rose(enable) |-> !en_eff ##1 !en_eff ##1 en_eff)
      else $error("enable not delayed by two cycles");
  end
endmodule

// File: sim/iea_bus_model.sv
// far side of the serial pins: a master engine's frames as seen on the wires
// assumes pulled-up lines, a 64 ns serial clock that stands high outside frames
`timescale 1ns/10ps
module iea_bus_model (
  // frame control
  input wire logic i_go,
  input wire logic i_stop_req,
  // pins and state
  output logic o_scl,
  output logic o_sda,
  output logic o_busy
);
  logic [7:0] pat; // data pattern, shifts every byte so lines never repeat
  // one frame per rising go: start, up to eight bytes, stop
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    o_busy = 1'b0;
    pat = 8'hA5;
    forever begin
      @(posedge i_go);
      o_busy = 1'b1;
      #7 o_sda = 1'b0; // start: data falls while clock high
      #32 o_scl = 1'b0;
      for (int n = 0; n < 8; n++) begin
        for (int b = 0; b < 9; b++) begin
          #16 o_sda = pat[b & 7];
          #16 o_scl = 1'b1;
          #32 o_scl = 1'b0;
        end
        pat = {pat[6:0], pat[7] ^ pat[5]};
        // give the engine time to see the byte end before ending the frame
        #64;
        if (i_stop_req) begin
          break;
        end
      end
      #16 o_sda = 1'b0;
      #16 o_scl = 1'b1;
      #32 o_sda = 1'b1; // stop: data rises while clock high, lines then idle high
      o_busy = 1'b0;
    end
  end
endmodule

// File: sim/tb_iea_ctrl.sv
// self-checking bench for the enable, abort and command-hold control
// assumes default parameters: depth 16, asynchronous clock relation
`timescale 1ns/10ps
module tb_iea_ctrl;
  import iea_pkg::*;
  localparam int LW = 5; // level width for a depth of 16
  // selectors of the levels that the bounded wait can watch
  localparam int W_START = 0;
  localparam int W_STOP = 1;
  localparam int W_IRQ = 2;
  localparam int W_NACK = 3;
  localparam int W_BUSY = 4;
  logic i_clk, i_rst_b, i_wr, i_rd, i_mst_active, i_slv_active, i_receiving;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rnd;
  logic [LW-1:0] i_tx_level, i_rx_level;
  logic o_en_core, o_start_en, o_stop_req, o_nack_req, o_tx_flush, o_rx_flush, o_abort_irq;
  logic scl, sda, bm_busy, go, rx_mode, rd_seen;
  logic [31:0] exp_q[$], mask_q[$]; // expected read data, oldest first
  int bad_count, tests_run;
  iea_ctrl iea_ctrl_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(scl),
    .i_sda(sda), .i_tx_level(i_tx_level), .i_rx_level(i_rx_level),
    .i_mst_active(i_mst_active), .i_slv_active(i_slv_active), .i_receiving(i_receiving),
    .o_en_core(o_en_core), .o_start_en(o_start_en), .o_stop_req(o_stop_req),
    .o_nack_req(o_nack_req), .o_tx_flush(o_tx_flush), .o_rx_flush(o_rx_flush),
    .o_abort_irq(o_abort_irq));
  iea_bus_model iea_bus_model_inst (.i_go(go), .i_stop_req(o_stop_req), .o_scl(scl),
    .o_sda(sda), .o_busy(bm_busy));
  // core clock, 8 ns
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // engine state follows the far side's frame
  always @(posedge i_clk) begin
    i_mst_active <= bm_busy;
    i_receiving <= bm_busy & rx_mode;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // read data watcher: compares the cycle after each read strobe
  always @(negedge i_clk) begin
    if (rd_seen) begin
      check(o_rdata & mask_q.pop_front(), exp_q.pop_front());
    end
    rd_seen = i_rd;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge i_clk);
    mask_q.push_back(m);
    exp_q.push_back(e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask
  task automatic look(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // live value of a watched level, picked by selector
  function automatic logic pick(input int sel);
    logic [4:0] lv;
    lv = {bm_busy, o_nack_req, o_abort_irq, o_stop_req, o_start_en};
    return lv[sel];
  endfunction
  // bounded wait for a level; running out ends the run
  task automatic wait_lvl(input int sel, input logic v, input int lim);
    for (int k = 0; k < lim && pick(sel) !== v; k++) begin
      @(negedge i_clk);
    end
    check({31'h0, pick(sel)}, {31'h0, v});
    if (pick(sel) !== v) begin
      finish_test();
    end
  endtask
  // watchdog against a hang anywhere
  initial begin
    repeat (100000) @(posedge i_clk);
    bad_count++;
    finish_test();
  end
  initial begin
    i_rst_b = 1'b0;
    {i_wr, i_rd, i_slv_active, go, rx_mode, rd_seen} = 6'h00;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_tx_level = '0;
    i_rx_level = '0;
    bad_count = 0;
    tests_run = 0;
    rnd = 32'h040FF66C;
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    look(1);
    check({31'h0, o_tx_flush & o_rx_flush & ~o_en_core}, 32'h1);
    rd(IEA_OFS_ENABLE, 32'hFFFFFFFF, 32'h0);
    rd(IEA_OFS_STATUS, 32'h1E, 32'h6);
    rnd = lfsr(rnd);
    rd({2'b10, rnd[5:0]}, 32'hFFFFFFFF, 32'h0);
    // abort while disabled, then junk in the reserved bits
    wr(IEA_OFS_ENABLE, 32'h2);
    rd(IEA_OFS_ENABLE, 32'hFFFFFFFF, 32'h0);
    rnd = lfsr(rnd);
    wr(IEA_OFS_ENABLE, {rnd[31:3], 3'b000});
    rd(IEA_OFS_ENABLE, 32'hFFFFFFFF, 32'h0);
    // enable reaches the core exactly three edges after the write edge
    rnd = lfsr(rnd);
    wr(IEA_OFS_ENABLE, {rnd[31:3], 3'b001});
    look(3);
    check({31'h0, o_en_core}, 32'h0);
    look(1);
    check({30'h0, o_en_core, o_rx_flush}, 32'h2);
    // hold set while empty and idle, then commands arrive
    wr(IEA_OFS_ENABLE, 32'h5);
    rnd = lfsr(rnd);
    i_tx_level <= LW'({rnd[3:0] | 4'h1});
    i_rx_level <= LW'({rnd[7:4] | 4'h1});
    look(8);
    check({31'h0, o_start_en}, 32'h0);
    rd(IEA_OFS_ENABLE, 32'hFFFFFFFF, 32'h5);
    wr(IEA_OFS_ENABLE, 32'h1);
    wait_lvl(W_START, 1'b1, 8);
    // abort in mid byte; a written zero must not cancel it
    go <= 1'b1;
    look(20);
    wr(IEA_OFS_ENABLE, 32'h3);
    go <= 1'b0;
    rd(IEA_OFS_ENABLE, 32'hFFFFFFFF, 32'h3);
    wr(IEA_OFS_ENABLE, 32'h1);
    rd(IEA_OFS_ENABLE, 32'hFFFFFFFF, 32'h3);
    look(1);
    check({31'h0, o_stop_req}, 32'h0);
    wait_lvl(W_STOP, 1'b1, 200);
    wait_lvl(W_IRQ, 1'b1, 300);
    rd(IEA_OFS_ENABLE, 32'hFFFFFFFF, 32'h1);
    look(1);
    check({31'h0, o_tx_flush}, 32'h1);
    rd(IEA_OFS_INTR, 32'h40, 32'h40);
    rd(IEA_OFS_ABRT_CLR, 32'h1, 32'h1);
    look(3);
    check({30'h0, o_tx_flush, o_abort_irq}, 32'h0);
    // disable in mid receive while the master owns the bus
    rx_mode <= 1'b1;
    go <= 1'b1;
    look(20);
    wr(IEA_OFS_ENABLE, 32'h0);
    go <= 1'b0;
    wait_lvl(W_NACK, 1'b1, 10);
    check({31'h0, o_stop_req}, 32'h0);
    rd(IEA_OFS_STATUS, 32'h1E, 32'h6);
    wait_lvl(W_STOP, 1'b1, 200);
    look(1);
    check({30'h0, o_tx_flush, o_rx_flush}, 32'h3);
    wait_lvl(W_BUSY, 1'b0, 300);
    finish_test();
  end
endmodule
